/* File: core/guarded_watchdog_timer.sv */
// Functional notes
// - 8-bit up-counter; rolling FF to 00 raises internal reset and sets flag.
// - counter holds zero after reset.
// - counter write enable changes only when its guard bit 7 is written 0.
// - guard bits 7, 5, 3, 1 always read back as one.
// - counter writes accepted only while counter write enable is one.
// - master write enable changes only when its guard bit 5 is written 0.
// - run enable and flag writable only while master write enable is one.
// - counter increments per selected tick while running, holds otherwise.
// - run enable set or cleared by guarded write; cleared by pin reset.
// - run enable written only with bit 3 guard written zero.
// - overflow flag set whenever the counter overflows.
// - flag cleared by pin reset or guarded zero write under master enable.
// - flag written only with bit 1 guard written zero.
// - select codes 1000-1111 pick clock/64 to /8192; 0xxx picks oscillator.
// - clock select bits 7 to 4 reserved, unwritable, read as one.
// - presetting the counter gives 1 to 256 ticks until overflow.
// - oscillator source keeps counting in every chip operating mode.
// - internal reset stays asserted for 512 oscillator cycles.
// - written counter value becomes the count; counting continues from it.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "wd_cfg.svh"

module guarded_watchdog_timer #(
  parameter int RST_OSC_CYCLES = `WD_RST_OSC_CYCLES
) (
  input wire logic clock, // system clock, 20 MHz
  input wire logic rst_b, // external reset pin, async, low
  input wire wd_pkg::reg_req_t req, // register access from software
  input wire logic osc_clk, // internal oscillator level
  input wire logic standby, // chip in a low-power mode
  output logic [7:0] rdata, // read data, cycle after read strobe
  output logic internal_reset, // chip reset request, active high
  output logic count_running // run enable as seen by the counter
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic counter_write_enable_r;
  logic master_write_enable_r;
  logic run_enable_r;
  logic overflow_reset_flag_r;
  logic [7:0] wd_count_reg_r;
  logic [3:0] clk_sel_r;
  logic [`WD_PRE_W-1:0] pre_r;
  logic osc_q_r;
  logic [7:0] rdata_r;
  logic internal_reset_r;
  logic [`WD_RST_CNT_W-1:0] rst_cnt_r;
  wd_pkg::rst_state_t rst_state_r;
  wd_pkg::rst_state_t rst_state_nxt;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // true once every 2**(base+sel) clock cycles; no edge on a tap
  // switch, so changing the source never makes a spurious tick
  function automatic logic tap_hit(
    input logic [`WD_PRE_W-1:0] pre,
    input logic [2:0] sel
  );
    logic [`WD_PRE_W-1:0] mask;
    mask = `WD_PRE_W'((1 << (`WD_TAP_BASE + int'(sel))) - 1);
    tap_hit = ((pre & mask) == mask);
  endfunction : tap_hit

  // read image of the control/status register
  function automatic logic [7:0] ctrl_image(
    input logic cwe,
    input logic mwe,
    input logic run,
    input logic flag
  );
    ctrl_image = 8'hff; // guard positions stay one
    ctrl_image[`WD_B_CNT_WE] = cwe;
    ctrl_image[`WD_B_MST_WE] = mwe;
    ctrl_image[`WD_B_RUN] = run;
    ctrl_image[`WD_B_FLAG] = flag;
  endfunction : ctrl_image

  ////////////////////////////////////////////////////////////////////////
  // access decode

  logic wr_ctrl;
  logic wr_count;
  logic wr_clksel;
  logic ctrl_guarded_ok;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_count = 1'b0;
    wr_clksel = 1'b0;
    if (req.wr && req.addr == `WD_OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (req.wr && req.addr == `WD_OFF_COUNT) begin
      wr_count = counter_write_enable_r;
    end else if (req.wr && req.addr == `WD_OFF_CLKSEL) begin
      wr_clksel = 1'b1;
    end
  end

  // the master enable in force before this write gates the lower bits
  assign ctrl_guarded_ok = wr_ctrl && master_write_enable_r;

  ////////////////////////////////////////////////////////////////////////
  // tick generation

  logic osc_rise;
  logic sys_tick;
  logic sel_tick;

  // inputs are synchronous, so one flop suffices for the edge
  assign osc_rise = osc_clk && !osc_q_r;

  // divided system clocks stop in standby; the oscillator never does
  assign sys_tick = tap_hit(pre_r, clk_sel_r[2:0]) && !standby;

  // top select bit low picks the oscillator
  assign sel_tick = clk_sel_r[3] ? sys_tick : osc_rise;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
      osc_q_r <= 1'b0;
    end else begin
      pre_r <= pre_r + `WD_PRE_W'(1);
      osc_q_r <= osc_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter

  logic overflow;

  // overflow on the tick that leaves FF; a counter write in the same
  // cycle wins, so a late kick still rescues the chip
  assign overflow = sel_tick && run_enable_r && !wr_count &&
                    (wd_count_reg_r == `WD_COUNT_MAX);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wd_count_reg_r <= `WD_COUNT_RST;
    end else if (wr_count) begin
      wd_count_reg_r <= req.wdata;
    end else if (sel_tick && run_enable_r) begin
      wd_count_reg_r <= wd_count_reg_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control/status bits

  // write enables carry their own guard bit in the same byte
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      counter_write_enable_r <= 1'b0;
      master_write_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (!req.wdata[`WD_B_CNT_GUARD]) begin
        counter_write_enable_r <= req.wdata[`WD_B_CNT_WE];
      end
      if (!req.wdata[`WD_B_MST_GUARD]) begin
        master_write_enable_r <= req.wdata[`WD_B_MST_WE];
      end
    end
  end

  // starting the timer takes two writes: open the master, then run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_enable_r <= 1'b0;
    end else if (ctrl_guarded_ok && !req.wdata[`WD_B_RUN_GUARD]) begin
      run_enable_r <= req.wdata[`WD_B_RUN];
    end
  end

  // set wins over a clear in the same cycle; writing one does nothing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_reset_flag_r <= 1'b0;
    end else if (overflow) begin
      overflow_reset_flag_r <= 1'b1;
    end else if (ctrl_guarded_ok && !req.wdata[`WD_B_FLAG_GUARD] &&
                 !req.wdata[`WD_B_FLAG]) begin
      overflow_reset_flag_r <= 1'b0;
    end
  end

  // clock select; the upper nibble has no storage at all
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clk_sel_r <= `WD_CLKSEL_RST;
    end else if (wr_clksel) begin
      clk_sel_r <= req.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal reset sequencer

  // the pulse is timed on oscillator edges so it has a fixed length
  // whatever prescaler tap was chosen
  always_comb begin
    rst_state_nxt = rst_state_r;
    case (rst_state_r)
      wd_pkg::RST_IDLE: begin
        if (overflow) begin
          rst_state_nxt = wd_pkg::RST_HOLD;
        end
      end
      wd_pkg::RST_HOLD: begin
        if (!overflow && osc_rise &&
            rst_cnt_r == `WD_RST_CNT_W'(RST_OSC_CYCLES - 1)) begin
          rst_state_nxt = wd_pkg::RST_IDLE;
        end
      end
      default: begin
        rst_state_nxt = wd_pkg::RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_state_r <= wd_pkg::RST_IDLE;
      internal_reset_r <= 1'b0;
    end else begin
      rst_state_r <= rst_state_nxt;
      internal_reset_r <= (rst_state_nxt == wd_pkg::RST_HOLD);
    end
  end

  // a fresh overflow during the pulse restarts its length
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_r <= '0;
    end else if (overflow || rst_state_r == wd_pkg::RST_IDLE) begin
      rst_cnt_r <= '0;
    end else if (osc_rise) begin
      rst_cnt_r <= rst_cnt_r + `WD_RST_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  // data stand only in the cycle after the strobe, else zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (!req.rd) begin
      rdata_r <= 8'h00;
    end else if (req.addr == `WD_OFF_CTRL) begin
      rdata_r <= ctrl_image(counter_write_enable_r,
                            master_write_enable_r, run_enable_r,
                            overflow_reset_flag_r);
    end else if (req.addr == `WD_OFF_COUNT) begin
      rdata_r <= wd_count_reg_r;
    end else if (req.addr == `WD_OFF_CLKSEL) begin
      rdata_r <= {`WD_CLKSEL_RSVD, clk_sel_r};
    end else begin
      rdata_r <= 8'h00; // unmapped
    end
  end

  assign rdata = rdata_r;
  assign internal_reset = internal_reset_r;
  assign count_running = run_enable_r;

endmodule : guarded_watchdog_timer
`default_nettype wire

/* File: core/wd_cfg.svh */
`ifndef WD_CFG_SVH
`define WD_CFG_SVH
// register byte addresses on the plain register port
`define WD_ADDR_W 2
`define WD_OFF_CTRL 2'h0
`define WD_OFF_COUNT 2'h1
`define WD_OFF_CLKSEL 2'h2
// control/status field positions
`define WD_B_CNT_GUARD 7
`define WD_B_CNT_WE 6
`define WD_B_MST_GUARD 5
`define WD_B_MST_WE 4
`define WD_B_RUN_GUARD 3
`define WD_B_RUN 2
`define WD_B_FLAG_GUARD 1
`define WD_B_FLAG 0
// reset values, reserved read value and full count
`define WD_COUNT_RST 8'h00
`define WD_CLKSEL_RST 4'h0f
`define WD_CLKSEL_RSVD 4'h0f
`define WD_COUNT_MAX 8'hff
// prescaler: first tap divides by 64, last by 8192
`define WD_PRE_W 13
`define WD_TAP_BASE 6
// internal reset length in oscillator cycles
`define WD_RST_OSC_CYCLES 512
`define WD_RST_CNT_W 10
`endif

/* File: core/wd_pkg.sv */
`include "wd_cfg.svh"
package wd_pkg;
  // one register port access, as it arrives from software
  typedef struct packed {
    logic [`WD_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // internal reset pulse sequencer
  typedef enum logic [0:0] {
    RST_IDLE = 1'b0,
    RST_HOLD = 1'b1
  } rst_state_t;
endpackage : wd_pkg

/* File: test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  wd_pkg::reg_req_t req = '0;
  logic osc_clk = 1'b0;
  logic standby = 1'b0;
  logic [7:0] rdata, exp_v, pre, n;
  logic internal_reset, count_running;
  logic rd_d = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic [3:0] code;
  logic [31:0] seed = 32'h0001_3f68;
  logic [7:0] exp_q[$];
  int p, k;
  int n_mismatch = 0;
  int n_tests = 0;
  guarded_watchdog_timer #(.RST_OSC_CYCLES(4)) i_guarded_watchdog_timer (
    .clock(clock), .rst_b(rst_b), .req(req), .osc_clk(osc_clk),
    .standby(standby), .rdata(rdata), .internal_reset(internal_reset),
    .count_running(count_running));
  initial forever #25 clock = ~clock;
  // oscillator rises every fourth clock, so a window of 8 holds two ticks
  always @(posedge clock) begin
    osc_div <= osc_div + 2'h1;
    osc_clk <= osc_div[1];
    rd_d <= req.rd;
  end
  // read data stands only in the cycle after the strobe
  always @(negedge clock) if (rd_d) begin
    exp_v = exp_q.pop_front();
    `CHK(rdata, exp_v)
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // one access; for a read d is the expected data
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) exp_q.push_back(d);
    @(posedge clock);
    req <= '0;
  endtask : acc
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    acc(1'b0, 2'h0, 8'haa);
    acc(1'b0, 2'h1, 8'h00);
    acc(1'b0, 2'h2, 8'hff);
    acc(1'b0, 2'h3, 8'h00);
    // counter locked, and guard bit 7 high leaves the lock alone
    acc(1'b1, 2'h1, 8'h55);
    acc(1'b1, 2'h0, 8'hc0);
    acc(1'b1, 2'h1, 8'h55);
    acc(1'b0, 2'h1, 8'h00);
    acc(1'b1, 2'h0, 8'h50);
    acc(1'b1, 2'h0, 8'ha4);
    acc(1'b0, 2'h0, 8'hfe);
    `CHK(count_running, 1'b1)
    // each source: preset, wait a window, expect the exact tick count
    for (int i = 0; i < 10; i++) begin
      code = (i < 8) ? 4'(8 + i) : ((i == 8) ? 4'h0 : 4'h8);
      p = code[3] ? (1 << (code[2:0] + 6)) : 8;
      n = (i == 9) ? 8'h00 : (code[3] ? 8'h01 : 8'h02);
      seed = xs(seed);
      pre = {1'b0, seed[6:0]};
      acc(1'b1, 2'h2, {seed[11:8], code});
      acc(1'b0, 2'h2, {4'hf, code});
      standby <= (i > 7);
      acc(1'b1, 2'h1, pre);
      // the read samples one edge after the last wait, so the count seen
      // covers exactly p edges after the preset: one tick period for a divided clock, two for the oscillator
      repeat (p - 1) @(posedge clock);
      acc(1'b0, 2'h1, pre + n);
    end
    standby <= 1'b0;
    // one tick from full count overflows
    acc(1'b1, 2'h2, 8'h08);
    acc(1'b1, 2'h1, 8'hff);
    for (k = 0; k < 80 && internal_reset !== 1'b1; k++) @(posedge clock);
    `CHK(internal_reset, 1'b1)
    acc(1'b0, 2'h0, 8'hff);
    acc(1'b0, 2'h1, 8'h00);
    acc(1'b1, 2'h0, 8'ha2);
    acc(1'b1, 2'h0, 8'haa);
    acc(1'b0, 2'h0, 8'hfb);
    acc(1'b1, 2'h0, 8'ha8);
    acc(1'b0, 2'h0, 8'hfa);
    acc(1'b1, 2'h1, 8'h10);
    repeat (70) @(posedge clock);
    acc(1'b0, 2'h1, 8'h10);
    acc(1'b1, 2'h0, 8'h8a);
    acc(1'b1, 2'h0, 8'ha6);
    acc(1'b0, 2'h0, 8'hea);
    `CHK(count_running, 1'b0)
    `CHK(internal_reset, 1'b0)
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

/* File: test/wd_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module wd_checker #(
  parameter int RST_OSC_CYCLES = 512
) (
  input wire logic clock, // system clock
  input wire logic rst_b, // pin reset, low
  input wire wd_pkg::reg_req_t req, // register access
  input wire logic osc_clk, // oscillator level
  input wire logic standby, // low-power mode
  input wire logic [7:0] rdata, // read data
  input wire logic internal_reset, // chip reset request
  input wire logic count_running // run enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic osc_r;
  int n_osc_r;
  wire logic ctl_wr = req.wr && req.addr == 2'h0;
  // counts oscillator rises while the chip reset is held
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      osc_r <= 1'b0;
      n_osc_r <= 0;
    end else begin
      osc_r <= osc_clk;
      if (!internal_reset) n_osc_r <= 0;
      else if (osc_clk && !osc_r) n_osc_r <= n_osc_r + 1;
    end
  end
  chk_guard_ones: assert property ($past(req.rd && req.addr == 2'h0)
    |-> (rdata & 8'haa) == 8'haa) else $error("guard bit read low");
  chk_rsvd_ones: assert property ($past(req.rd && req.addr == 2'h2)
    |-> rdata[7:4] == 4'hf) else $error("reserved bits read low");
  chk_rdata_idle: assert property (!$past(req.rd)
    |-> rdata == 8'h00) else $error("read data outside read cycle");
  chk_run_set: assert property ($rose(count_running)
    |-> $past(ctl_wr && !req.wdata[3] && req.wdata[2]))
    else $error("run enable set without guarded write");
  chk_run_clear: assert property ($fell(count_running)
    |-> $past(ctl_wr && !req.wdata[3] && !req.wdata[2]))
    else $error("run enable cleared without guarded write");
  chk_run_hold: assert property (!ctl_wr |=> $stable(count_running))
    else $error("run enable moved without control write");
  chk_rst_cause: assert property ($rose(internal_reset)
    |-> $past(count_running) || $past(count_running, 2))
    else $error("chip reset while stopped");
  chk_rst_length: assert property ($fell(internal_reset)
    |-> $past(n_osc_r) >= RST_OSC_CYCLES - 1)
    else $error("chip reset too short");
  cover property ($rose(internal_reset));
  cover property ($fell(internal_reset));
  cover property ($rose(count_running));
endmodule : wd_checker
bind guarded_watchdog_timer wd_checker #(.RST_OSC_CYCLES(RST_OSC_CYCLES))
  i_wd_checker (.clock(clock), .rst_b(rst_b), .req(req), .osc_clk(osc_clk),
  .standby(standby), .rdata(rdata), .internal_reset(internal_reset),
  .count_running(count_running));
`default_nettype wire
